//--- rtl/dmrac_pkg.sv
/*
  Constants, register map and state encodings for the DRAM mode register
  access control block. Assumes a 100 MHz controller clock and an
  AXI4-Lite register port with 32-bit data.
*/
package dmrac_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_MRC0 = 8'h00;   // mode_reg_ctrl0
  localparam logic [7:0] ADDR_MRC1 = 8'h04;   // mode_reg_ctrl1
  localparam logic [7:0] ADDR_MODE_REG_STATUS = 8'h08; // mode_reg_status
  localparam logic [7:0] ADDR_PWR = 8'h0C;    // power_ctrl
  localparam logic [7:0] ADDR_HWLP = 8'h10;   // hw_low_power_ctrl
  localparam logic [7:0] ADDR_PHYM = 8'h14;   // phy_master_ctrl
  localparam logic [7:0] ADDR_DERATE = 8'h18; // temp_derating_ctrl
  localparam logic [7:0] ADDR_MODE = 8'h1C;   // Memory type select
  localparam logic [7:0] ADDR_OPSTAT = 8'h20; // Operating status
  // Field positions
  localparam int MRC0_REQ_BIT = 0;  // mode_reg_write_request
  localparam int PWR_MPSM_BIT = 0;  // Maximum power saving enable
  localparam int PWR_AUTO_BIT = 1;  // Automatic self-refresh enable
  localparam int PWR_SW_BIT = 2;    // sw_self_refresh_request
  localparam int PWR_HOLD_BIT = 3;  // Hold in self-refresh
  // Reset values
  localparam logic [3:0] PWR_RST = 4'h0;
  localparam logic PHYM_RST = 1'b1;
  localparam logic DERATE_RST = 1'b0;
  localparam logic HWLP_RST = 1'b0;
  localparam logic LP4_RST = 1'b0;
  // Operating mode codes
  localparam logic [2:0] OPMODE_NORMAL = 3'b001;
  localparam logic [2:0] OPMODE_SR = 3'b011;
  // Self-refresh cause codes
  localparam logic [1:0] CAUSE_NONE = 2'b00;
  localparam logic [1:0] CAUSE_PHY = 2'b01;
  localparam logic [1:0] CAUSE_SW = 2'b10;
  localparam logic [1:0] CAUSE_AUTO = 2'b11;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RW2MRW_NS = 40;                 // Least read/write to MRW gap
  localparam int RW2MRW_CYC = (T_RW2MRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_DERATE_NS = 3900;               // Periodic derating read interval
  localparam int DERATE_CYC = T_DERATE_NS / CLK_PERIOD_NS;
  localparam int AUTO_SR_IDLE_CYC = 64;            // Idle cycles before auto entry
  // Self-refresh phase
  typedef enum logic [1:0] {
    SR_NONE = 2'b00,
    SR_ONE = 2'b01,
    SR_PD = 2'b10,
    SR_TWO = 2'b11
  } dmrac_sr_type;
  // Arbiter state
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_SW = 2'b01,
    ARB_HW = 2'b10
  } dmrac_arb_type;
endpackage

//--- rtl/dmrac_arb.sv
/*
  Arbiter between software and hardware mode register accesses.
  Assumes requests stay high until granted and one done pulse per grant.
*/
`timescale 1ns/10ps
module dmrac_arb (
  input wire logic clk_i,      // Controller clock
  input wire logic rst_n_i,    // Async reset, active low
  input wire logic ce_i,       // Clock enable
  input wire logic sw_req_i,   // Software access ready to go
  input wire logic hw_req_i,   // Hardware access queued
  input wire logic done_i,     // Current access finished
  output logic grant_sw_o,     // Software access launched
  output logic grant_hw_o,     // Hardware access launched
  output logic sw_done_o       // Software access finished
);
  dmrac_pkg::dmrac_arb_type state_reg; // Who owns the mode register path
  dmrac_pkg::dmrac_arb_type state_next;

  // Software wins a tie; nothing launches while an access is open
  always_comb begin
    state_next = state_reg;
    grant_sw_o = 1'b0;
    grant_hw_o = 1'b0;
    sw_done_o = 1'b0;
    case (state_reg)
      dmrac_pkg::ARB_IDLE: begin
        if (sw_req_i) begin
          state_next = dmrac_pkg::ARB_SW;
          grant_sw_o = 1'b1;
        end else if (hw_req_i) begin
          state_next = dmrac_pkg::ARB_HW;
          grant_hw_o = 1'b1;
        end
      end
      dmrac_pkg::ARB_SW: begin
        // Software done is reported on its own completion only
        if (done_i) begin
          state_next = dmrac_pkg::ARB_IDLE;
          sw_done_o = 1'b1;
        end
      end
      dmrac_pkg::ARB_HW: begin
        if (done_i) begin
          state_next = dmrac_pkg::ARB_IDLE;
        end
      end
      default: state_next = dmrac_pkg::ARB_IDLE;
    endcase
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= dmrac_pkg::ARB_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  chk_sw_priority: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_reg == dmrac_pkg::ARB_IDLE && sw_req_i && hw_req_i
    |=> state_reg == dmrac_pkg::ARB_SW)
    else $error("software access lost a tie");
  chk_no_preempt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_reg == dmrac_pkg::ARB_HW && sw_req_i && !done_i
    |=> state_reg == dmrac_pkg::ARB_HW && !grant_sw_o)
    else $error("software access overlapped a hardware access");
  cov_hw_then_sw: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == dmrac_pkg::ARB_HW && sw_req_i ##[1:40] grant_sw_o);
endmodule

//--- rtl/dmrac_top.sv
/*
  Mode register access control: AXI4-Lite register file, software and
  hardware mode register access launch, self-refresh sequencing.
  Assumes a command scheduler on the same clock returning cmd_done_i,
  reporting each read/write issue on rw_cmd_i, and a PHY master request
  pin from outside the clock domain.
*/
`timescale 1ns/10ps
// Operation
// - Writing request bit launches software access
// - Pending flag clears on own completion
// - Hardware issues its own mode register accesses
// - No software MRW inside read/write-to-MRW gap, in LPDDR4 only
module dmrac_top #(
  parameter int DERATE_PERIOD_CYC = dmrac_pkg::DERATE_CYC // Derating read interval
) (
  input wire logic clk_i,            // Controller clock
  input wire logic rst_n_i,          // Async reset, active low
  input wire logic ce_i,             // Clock enable, freezes all state
  input wire logic [7:0] awaddr_i,   // AXI write address
  input wire logic awvalid_i,        // AXI write address valid
  output logic awready_o,            // AXI write address ready
  input wire logic [31:0] wdata_i,   // AXI write data
  input wire logic [3:0] wstrb_i,    // AXI write strobes
  input wire logic wvalid_i,         // AXI write data valid
  output logic wready_o,             // AXI write data ready
  output logic [1:0] bresp_o,        // AXI write response
  output logic bvalid_o,             // AXI write response valid
  input wire logic bready_i,         // AXI write response ready
  input wire logic [7:0] araddr_i,   // AXI read address
  input wire logic arvalid_i,        // AXI read address valid
  output logic arready_o,            // AXI read address ready
  output logic [31:0] rdata_o,       // AXI read data
  output logic [1:0] rresp_o,        // AXI read response
  output logic rvalid_o,             // AXI read data valid
  input wire logic rready_i,         // AXI read data ready
  input wire logic rw_cmd_i,         // Read/write command issued this cycle
  input wire logic cmd_done_i,       // Mode register command completed
  input wire logic phy_mstr_req_i,   // PHY master request pin
  output logic mr_cmd_valid_o,       // Mode register command launch pulse
  output logic mr_cmd_hw_o,          // Launched command is hardware-driven
  output logic [31:0] mr_cmd_ctrl_o, // Command control word
  output logic [31:0] mr_cmd_data_o, // Command data word
  output logic [1:0] sr_phase_o      // Self-refresh phase to DRAM side
);
  // Byte-strobe merge of a write into a stored word
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Bus state
  logic aw_hold_reg, aw_hold_next;     // Write address captured
  logic w_hold_reg, w_hold_next;       // Write data captured
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // Configuration state
  logic [31:0] mrc0_reg, mrc0_next;    // Command control, bit 0 self-clears
  logic [31:0] mrc1_reg, mrc1_next;    // Command data
  logic [3:0] pwr_reg, pwr_next;       // power_ctrl fields
  logic hwlp_reg, hwlp_next;           // hw_low_power_enable
  logic phym_reg, phym_next;           // PHY master interface enable
  logic derate_reg, derate_next;       // Temperature derating enable
  logic lp4_reg, lp4_next;             // 1 = LPDDR4, 0 = DDR4
  logic pending_reg, pending_next;     // mode_reg_write_pending
  // Access and self-refresh state
  dmrac_pkg::dmrac_sr_type sr_reg, sr_next;
  logic [1:0] cause_reg, cause_next;
  logic [6:0] idle_reg, idle_next;     // Idle count for automatic entry
  logic [7:0] gap_reg, gap_next;       // Read/write to MRW guard count
  logic [15:0] der_cnt_reg, der_cnt_next;
  logic hw_pend_reg, hw_pend_next;     // Hardware access queued
  logic mv_reg, mv_next, mhw_reg, mhw_next;
  logic [31:0] mctrl_reg, mctrl_next, mdata_reg, mdata_next;
  logic phy_s1_reg, phy_s2_reg;        // PHY request synchroniser
  // Glue
  logic aw_hs, w_hs, ar_hs, do_wr, sw_set, sw_ok, grant_sw, grant_hw, sw_done;
  logic phy_req, auto_go, der_fire, sr_exit;

  assign aw_hs = awvalid_i && awready_reg;
  assign w_hs = wvalid_i && wready_reg;
  assign ar_hs = arvalid_i && arready_reg;
  assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
  // A request while one is still pending is dropped; software polls first
  assign sw_set = do_wr && aw_addr_reg == dmrac_pkg::ADDR_MRC0 && w_strb_reg[0]
                  && w_data_reg[dmrac_pkg::MRC0_REQ_BIT] && !pending_reg;
  // In LPDDR4 the launch waits out the read/write to MRW gap
  // A read/write issued this very cycle blocks too; the guard count only starts next cycle
  assign sw_ok = pending_reg && !(lp4_reg && (gap_reg != 8'h00 || rw_cmd_i));
  // Request honoured only while the enable reads 1, sampled live
  assign phy_req = phy_s2_reg && phym_reg;
  assign auto_go = pwr_reg[dmrac_pkg::PWR_AUTO_BIT]
                   && idle_reg == 7'(dmrac_pkg::AUTO_SR_IDLE_CYC);
  assign der_fire = lp4_reg && derate_reg && der_cnt_reg == 16'h0000;
  assign sr_exit = sr_reg == dmrac_pkg::SR_PD && sr_next == dmrac_pkg::SR_NONE;

  dmrac_arb u_arb (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .sw_req_i(sw_ok),
    .hw_req_i(hw_pend_reg),
    .done_i(cmd_done_i),
    .grant_sw_o(grant_sw),
    .grant_hw_o(grant_hw),
    .sw_done_o(sw_done)
  );

  // Bus slave and register file next values
  always_comb begin
    aw_hold_next = aw_hold_reg | aw_hs;
    w_hold_next = w_hold_reg | w_hs;
    aw_addr_next = aw_hs ? awaddr_i : aw_addr_reg;
    w_data_next = w_hs ? wdata_i : w_data_reg;
    w_strb_next = w_hs ? wstrb_i : w_strb_reg;
    bvalid_next = bvalid_reg && !bready_i;
    bresp_next = bresp_reg;
    mrc0_next = mrc0_reg;
    mrc1_next = mrc1_reg;
    pwr_next = pwr_reg;
    hwlp_next = hwlp_reg;
    phym_next = phym_reg;
    derate_next = derate_reg;
    lp4_next = lp4_reg;
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = dmrac_pkg::RESP_OKAY;
      case (aw_addr_reg)
        dmrac_pkg::ADDR_MRC0: mrc0_next = wmerge(mrc0_reg, w_data_reg, w_strb_reg) & ~32'h1;
        dmrac_pkg::ADDR_MRC1: mrc1_next = wmerge(mrc1_reg, w_data_reg, w_strb_reg);
        dmrac_pkg::ADDR_MODE_REG_STATUS: ; // Read-only, write ignored
        dmrac_pkg::ADDR_PWR: if (w_strb_reg[0]) pwr_next = w_data_reg[3:0];
        dmrac_pkg::ADDR_HWLP: if (w_strb_reg[0]) hwlp_next = w_data_reg[0];
        dmrac_pkg::ADDR_PHYM: if (w_strb_reg[0]) phym_next = w_data_reg[0];
        dmrac_pkg::ADDR_DERATE: if (w_strb_reg[0]) derate_next = w_data_reg[0];
        dmrac_pkg::ADDR_MODE: if (w_strb_reg[0]) lp4_next = w_data_reg[0];
        dmrac_pkg::ADDR_OPSTAT: ;
        default: bresp_next = dmrac_pkg::RESP_SLVERR; // Unmapped
      endcase
    end
    // One transfer of each kind at a time; ready drops while one is held
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next = !w_hold_next && !bvalid_next;
    rvalid_next = rvalid_reg && !rready_i;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_hs) begin
      rvalid_next = 1'b1;
      rresp_next = dmrac_pkg::RESP_OKAY;
      case (araddr_i)
        dmrac_pkg::ADDR_MRC0: rdata_next = mrc0_reg;
        dmrac_pkg::ADDR_MRC1: rdata_next = mrc1_reg;
        dmrac_pkg::ADDR_MODE_REG_STATUS: rdata_next = {31'h0, pending_reg};
        dmrac_pkg::ADDR_PWR: rdata_next = {28'h0, pwr_reg};
        dmrac_pkg::ADDR_HWLP: rdata_next = {31'h0, hwlp_reg};
        dmrac_pkg::ADDR_PHYM: rdata_next = {31'h0, phym_reg};
        dmrac_pkg::ADDR_DERATE: rdata_next = {31'h0, derate_reg};
        dmrac_pkg::ADDR_MODE: rdata_next = {31'h0, lp4_reg};
        // Software polls these for its self-refresh sequence
        dmrac_pkg::ADDR_OPSTAT: rdata_next = {24'h0, cause_reg, sr_reg, 1'b0,
          (sr_reg != dmrac_pkg::SR_NONE) ? dmrac_pkg::OPMODE_SR : dmrac_pkg::OPMODE_NORMAL};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = dmrac_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // Access launch, hardware sources and self-refresh next values
  always_comb begin
    // Set wins over the completion clear
    pending_next = sw_set | (pending_reg & !sw_done);
    // Periodic derating reads in LPDDR4, automatic MRS on DDR4 exit
    der_cnt_next = (lp4_reg && derate_reg && der_cnt_reg != 16'h0000)
                   ? der_cnt_reg - 16'h0001 : 16'(DERATE_PERIOD_CYC);
    hw_pend_next = der_fire | (sr_exit & !lp4_reg & hwlp_reg)
                   | (hw_pend_reg & !grant_hw);
    gap_next = rw_cmd_i ? 8'(dmrac_pkg::RW2MRW_CYC)
               : (gap_reg != 8'h00 ? gap_reg - 8'h01 : 8'h00);
    idle_next = (rw_cmd_i || sr_reg != dmrac_pkg::SR_NONE) ? 7'h00
                : (auto_go ? idle_reg : idle_reg + 7'h01);
    mv_next = grant_sw | grant_hw;
    mhw_next = grant_hw ? 1'b1 : (grant_sw ? 1'b0 : mhw_reg);
    mctrl_next = grant_sw ? mrc0_reg : (grant_hw ? 32'h0000_0000 : mctrl_reg);
    mdata_next = grant_sw ? mrc1_reg : (grant_hw ? 32'h0000_0000 : mdata_reg);
    sr_next = sr_reg;
    cause_next = cause_reg;
    case (sr_reg)
      dmrac_pkg::SR_NONE: begin
        if (pwr_reg[dmrac_pkg::PWR_SW_BIT]) begin
          sr_next = dmrac_pkg::SR_ONE;
          cause_next = dmrac_pkg::CAUSE_SW;
        end else if (phy_req) begin
          sr_next = dmrac_pkg::SR_ONE;
          cause_next = dmrac_pkg::CAUSE_PHY;
        end else if (auto_go) begin
          sr_next = dmrac_pkg::SR_ONE;
          cause_next = dmrac_pkg::CAUSE_AUTO;
        end
      end
      // Hold keeps the memory in SR1 so MRW meets no traffic
      dmrac_pkg::SR_ONE: if (!pwr_reg[dmrac_pkg::PWR_HOLD_BIT]) sr_next = dmrac_pkg::SR_PD;
      dmrac_pkg::SR_PD: begin
        if (pwr_reg[dmrac_pkg::PWR_HOLD_BIT]) begin
          sr_next = dmrac_pkg::SR_TWO;
        end else if ((cause_reg == dmrac_pkg::CAUSE_SW && !pwr_reg[dmrac_pkg::PWR_SW_BIT])
                     || (cause_reg == dmrac_pkg::CAUSE_PHY && !phy_s2_reg)
                     || (cause_reg == dmrac_pkg::CAUSE_AUTO
                         && (rw_cmd_i || !pwr_reg[dmrac_pkg::PWR_AUTO_BIT]))) begin
          sr_next = dmrac_pkg::SR_NONE;
          cause_next = dmrac_pkg::CAUSE_NONE;
        end
      end
      dmrac_pkg::SR_TWO: if (!pwr_reg[dmrac_pkg::PWR_HOLD_BIT]) sr_next = dmrac_pkg::SR_PD;
      default: sr_next = dmrac_pkg::SR_NONE;
    endcase
  end

  // PHY request crosses in through two flops before any use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_s1_reg <= 1'b0;
      phy_s2_reg <= 1'b0;
    end else if (ce_i) begin
      phy_s1_reg <= phy_mstr_req_i;
      phy_s2_reg <= phy_s1_reg;
    end
  end

  // All other registered state; nothing moves while ce_i is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      mrc0_reg <= 32'h0000_0000;
      mrc1_reg <= 32'h0000_0000;
      pwr_reg <= dmrac_pkg::PWR_RST;
      hwlp_reg <= dmrac_pkg::HWLP_RST;
      phym_reg <= dmrac_pkg::PHYM_RST;
      derate_reg <= dmrac_pkg::DERATE_RST;
      lp4_reg <= dmrac_pkg::LP4_RST;
      pending_reg <= 1'b0;
      sr_reg <= dmrac_pkg::SR_NONE;
      cause_reg <= dmrac_pkg::CAUSE_NONE;
      idle_reg <= 7'h00;
      gap_reg <= 8'h00;
      der_cnt_reg <= 16'h0000;
      hw_pend_reg <= 1'b0;
      mv_reg <= 1'b0;
      mhw_reg <= 1'b0;
      mctrl_reg <= 32'h0000_0000;
      mdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      mrc0_reg <= mrc0_next;
      mrc1_reg <= mrc1_next;
      pwr_reg <= pwr_next;
      hwlp_reg <= hwlp_next;
      phym_reg <= phym_next;
      derate_reg <= derate_next;
      lp4_reg <= lp4_next;
      pending_reg <= pending_next;
      sr_reg <= sr_next;
      cause_reg <= cause_next;
      idle_reg <= idle_next;
      gap_reg <= gap_next;
      der_cnt_reg <= der_cnt_next;
      hw_pend_reg <= hw_pend_next;
      mv_reg <= mv_next;
      mhw_reg <= mhw_next;
      mctrl_reg <= mctrl_next;
      mdata_reg <= mdata_next;
    end
  end

  assign awready_o = awready_reg;
  assign wready_o = wready_reg;
  assign bvalid_o = bvalid_reg;
  assign bresp_o = bresp_reg;
  assign arready_o = arready_reg;
  assign rvalid_o = rvalid_reg;
  assign rresp_o = rresp_reg;
  assign rdata_o = rdata_reg;
  assign mr_cmd_valid_o = mv_reg;
  assign mr_cmd_hw_o = mhw_reg;
  assign mr_cmd_ctrl_o = mctrl_reg;
  assign mr_cmd_data_o = mdata_reg;
  assign sr_phase_o = sr_reg;

  chk_req_launch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sw_set |=> pending_reg)
    else $error("request write did not raise pending");
  chk_pending_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sw_done && !sw_set |=> !pending_reg)
    else $error("pending stayed set after completion");
  chk_derate_queue: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && der_fire |=> hw_pend_reg || mr_cmd_valid_o)
    else $error("derating read not queued");
  chk_rw_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && lp4_reg && rw_cmd_i |=> !(mv_reg && !mhw_reg) [*4])
    else $error("software MRW inside read/write gap");
  chk_phym_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sr_reg == dmrac_pkg::SR_NONE && !phym_reg && !pwr_reg[dmrac_pkg::PWR_SW_BIT]
    && !auto_go |=> sr_reg == dmrac_pkg::SR_NONE)
    else $error("self-refresh entered with PHY master disabled");
  chk_hold_sr1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sr_reg == dmrac_pkg::SR_ONE && pwr_reg[dmrac_pkg::PWR_HOLD_BIT]
    |=> sr_reg == dmrac_pkg::SR_ONE)
    else $error("left SR1 while hold set");
  chk_sw_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && sr_reg == dmrac_pkg::SR_NONE && pwr_reg[dmrac_pkg::PWR_SW_BIT]
    |=> sr_reg == dmrac_pkg::SR_ONE && cause_reg == dmrac_pkg::CAUSE_SW)
    else $error("software self-refresh entry missed");
  chk_bvalid_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && bvalid_reg && !bready_i |=> bvalid_reg && $stable(bresp_reg))
    else $error("write response dropped before ready");
  cov_sw_access: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    sw_set ##[1:40] sw_done);
  cov_sr1_entry: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    sr_reg == dmrac_pkg::SR_NONE ##1 sr_reg == dmrac_pkg::SR_ONE);
  cov_status_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    ar_hs && araddr_i == dmrac_pkg::ADDR_MODE_REG_STATUS);
endmodule

//--- bench/dmrac_dram_model.sv
/* Stand-in for the command scheduler and DRAM side: it finishes each
   launched mode register command. Assumes the block's clock and reset. */
`timescale 1ns/10ps
module dmrac_dram_model #(
  parameter int DLY = 30 // Command run time in cycles
) (
  input wire logic clk_i,          // Controller clock
  input wire logic rst_n_i,        // Async reset, active low
  input wire logic mr_cmd_valid_i, // Launch pulse from the block
  output logic cmd_done_o          // Completion pulse to the block
);
  int cnt; // Cycles left; slow enough that the pending flag can be read
  // One completion for each launch, never before it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      cmd_done_o <= 1'b0;
    end else begin
      cmd_done_o <= (cnt == 1);
      cnt <= mr_cmd_valid_i ? DLY : (cnt != 0 ? cnt - 1 : 0);
    end
  end
endmodule

//--- bench/testbench.sv
/* Self-checking bench for the mode register access block.
   Assumes the scheduler model in dmrac_dram_model. */
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0, rst_n_i = 1'b0, done, aw = 0, w = 0, b = 0, ar = 0, r = 0, valid, hw;
  logic rw = 1'b0, phy = 1'b0; // Read/write traffic and PHY request pin
  logic [7:0] aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rdata, ctrl, data, got;
  logic [1:0] bresp, rresp, ph;
  logic awr, wr_o, bv, arr, rv;
  int err_total = 0, cmd_n = 0, hw_n = 0;
  int cmp_count = 0;
  dmrac_top #(.DERATE_PERIOD_CYC(20)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .awaddr_i(aa), .awvalid_i(aw), .awready_o(awr), .wdata_i(wd), .wstrb_i(4'hF),
    .wvalid_i(w), .wready_o(wr_o), .bresp_o(bresp), .bvalid_o(bv), .bready_i(b),
    .araddr_i(ra), .arvalid_i(ar), .arready_o(arr), .rdata_o(rdata), .rresp_o(rresp),
    .rvalid_o(rv), .rready_i(r), .rw_cmd_i(rw), .cmd_done_i(done), .phy_mstr_req_i(phy),
    .mr_cmd_valid_o(valid), .mr_cmd_hw_o(hw), .mr_cmd_ctrl_o(ctrl), .mr_cmd_data_o(data),
    .sr_phase_o(ph));
  dmrac_dram_model model (.clk_i(clk_i), .rst_n_i(rst_n_i), .mr_cmd_valid_i(valid),
    .cmd_done_o(done));
  initial forever #5 clk_i = ~clk_i;
  // Count launches; hardware ones separately
  always @(posedge clk_i) if (valid === 1'b1) begin
    cmd_n++;
    if (hw === 1'b1) hw_n++;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, s, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    aa <= a; wd <= d; aw <= 1; w <= 1; b <= 1;
    while (!(ad && dd)) begin
      @(posedge clk_i);
      if (awr && aw) begin aw <= 0; ad = 1; end
      if (wr_o && w) begin w <= 0; dd = 1; end
    end
    do @(posedge clk_i); while (bv !== 1'b1);
    b <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ra <= a; ar <= 1; r <= 1;
    do @(posedge clk_i); while (arr !== 1'b1);
    ar <= 0;
    do @(posedge clk_i); while (rv !== 1'b1);
    d = rdata;
    r <= 0;
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    rd(dmrac_pkg::ADDR_PHYM, got); chk(got, 32'h1);
    rd(dmrac_pkg::ADDR_PWR, got); chk(got, 32'h0);
    rd(8'h40, got); chk({rresp, got[29:0]}, {2'h2, 30'h0}); // Unmapped gives SLVERR
  endtask
  task automatic t_sw;
    wr(dmrac_pkg::ADDR_PHYM, 32'h0);
    wr(dmrac_pkg::ADDR_MRC1, 32'h0000_00A5);
    wr(dmrac_pkg::ADDR_MRC0, 32'h0000_0031);
    rd(dmrac_pkg::ADDR_MODE_REG_STATUS, got); chk(got, 32'h1);
    chk(cmd_n, 32'h1);
    chk(hw, 1'b0);
    chk(ctrl, 32'h30);
    chk(data, 32'hA5);
    repeat (40) @(posedge clk_i);
    rd(dmrac_pkg::ADDR_MODE_REG_STATUS, got); chk(got, 32'h0);
  endtask
  task automatic t_hw;
    wr(dmrac_pkg::ADDR_MODE, 32'h1);
    wr(dmrac_pkg::ADDR_DERATE, 32'h1);
    wr(dmrac_pkg::ADDR_MRC0, 32'h1);
    repeat (100) @(posedge clk_i);
    chk(hw_n != 0 && hw_n < cmd_n, 1'b1);
    wr(dmrac_pkg::ADDR_DERATE, 32'h0);
    repeat (40) @(posedge clk_i);
    got = hw_n;
    repeat (60) @(posedge clk_i);
    chk(hw_n, got);
  endtask
  // Traffic in flight holds a software MRW back until the guard gap has passed
  task automatic t_gap;
    rw <= 1'b1;
    wr(dmrac_pkg::ADDR_MRC0, 32'h1);
    got = cmd_n;
    repeat (20) @(posedge clk_i);
    chk(cmd_n, got);
    rd(dmrac_pkg::ADDR_MODE_REG_STATUS, data); chk(data, 32'h1);
    rw <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(cmd_n, got);
    repeat (40) @(posedge clk_i);
    chk(cmd_n, got + 32'h1);
  endtask
  task automatic t_sr;
    wr(dmrac_pkg::ADDR_PHYM, 32'h0);
    wr(dmrac_pkg::ADDR_PWR, 32'h0);
    do rd(dmrac_pkg::ADDR_OPSTAT, got); while (got[2:0] == dmrac_pkg::OPMODE_SR);
    wr(dmrac_pkg::ADDR_PWR, 32'h8);
    wr(dmrac_pkg::ADDR_PWR, 32'hC);
    repeat (4) @(posedge clk_i);
    rd(dmrac_pkg::ADDR_OPSTAT, got); chk(got[7:0], 8'h93);
    // MRW only while held in SR1, so no traffic can meet it
    wr(dmrac_pkg::ADDR_MRC0, 32'h1);
    repeat (40) @(posedge clk_i);
    rd(dmrac_pkg::ADDR_MODE_REG_STATUS, got); chk(got, 32'h0);
    wr(dmrac_pkg::ADDR_PWR, 32'h4);
    repeat (4) @(posedge clk_i);
    chk(ph, dmrac_pkg::SR_PD);
    // Hold again from power-down reaches SR2; software backs out as on a retry
    wr(dmrac_pkg::ADDR_PWR, 32'hC);
    chk(ph, dmrac_pkg::SR_TWO);
    wr(dmrac_pkg::ADDR_PWR, 32'h4);
    wr(dmrac_pkg::ADDR_PWR, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(ph, dmrac_pkg::SR_NONE);
    // PHY request ignored while its enable is 0, honoured once it is 1
    phy <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(ph, dmrac_pkg::SR_NONE);
    wr(dmrac_pkg::ADDR_PHYM, 32'h1);
    rd(dmrac_pkg::ADDR_OPSTAT, got); chk(got[7:0], 8'h63);
    phy <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(ph, dmrac_pkg::SR_NONE);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset;
    t_sw;
    t_hw;
    t_gap;
    t_sr;
    tally_and_finish;
  end
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end
endmodule
